// >>> core/idc_pkg.sv
// Purpose: Shared constants and types for the dual converter control
// Assumes: Two channels, one clock, no register bus
// Notes:   Rule summary follows
//
// What this block does
// - Converter fault latches high, survives recovery
// - Status read clears the latched fault
// - Per-channel two-bit input source selector
// - Per-channel three-bit gain, 1 to 128
// - Precharge buffer on for gain eight up
// - One bits key the carrier, zeros silent
// - Sinc decimation, results handed to host
// - Both channels sampled together, 16-bit results
// - Decimation reaches 64 kSPS in turbo
// - Per-channel configurable sampling phase offset
// - Offset and gain calibration on every sample
// - Sync pin pulse realigns all conversions
// - Modulator clock is divided clock, reset two
// - Resonator clock follows the modulator clock
// - Divider codes give 2, 4, 8, 12
// - SPI mode 0/1, select moves clock low

package idc_pkg;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	localparam int NCH        = 2;
	localparam int SAMPLE_W   = 16;
	localparam int PHASE_W    = 14;
	localparam int ACC_W      = 15;
	localparam int CAL_W      = 16;
	localparam int CAL_FRAC   = 15;
	localparam int FIFO_DEPTH = 8;
	localparam int ASYNC_W    = 6;

	// ------------------------------------------------------------
	// Timing and coding constants
	// ------------------------------------------------------------
	localparam int           CARRIER_MHZ        = 480;
	localparam logic [1:0]   DIV_CODE_RESET     = 2'h0;
	localparam logic [3:0]   HALF_2             = 4'h1;
	localparam logic [3:0]   HALF_4             = 4'h2;
	localparam logic [3:0]   HALF_8             = 4'h4;
	localparam logic [3:0]   HALF_12            = 4'h6;
	localparam logic [2:0]   PRECHARGE_MIN_GAIN = 3'h3;
	localparam logic [3:0]   OSR_LOG_TURBO      = 4'h6;
	localparam logic [3:0]   OSR_LOG_BASE       = 4'h7;
	localparam logic [3:0]   FULL_LOG           = 4'hf;
	localparam logic         SPI_CPOL           = 1'b0;
	localparam logic         SPI_CPHA           = 1'b1;
	localparam logic [15:0]  SAMPLE_MAX         = 16'h7fff;
	localparam logic [15:0]  SAMPLE_MIN         = 16'h8000;
	// Select and sync pins idle high, fault idle low
	localparam logic [5:0]   ASYNC_RST          = 6'h18;

	// Status word layout
	localparam int STS_FAULT   = 0;
	localparam int STS_SPI_ERR = 1;
	localparam int STS_OVERRUN = 2;
	localparam int STS_W       = 3;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_PINS,
		SRC_HIGH_SIDE_GROUND,
		SRC_TEST_POS,
		SRC_TEST_NEG
	} idc_src_e;

	typedef struct packed {
		idc_src_e                 input_source_select;
		logic [2:0]               channel_gain_select;
		logic [PHASE_W-1:0]       phase;
		logic signed [CAL_W-1:0]  cal_offset;
		logic [CAL_W-1:0]         cal_gain;
	} idc_ch_cfg_s;

	typedef struct packed {
		logic                        chan;
		logic signed [SAMPLE_W-1:0]  data;
	} idc_sample_s;

endpackage

// >>> core/idc_fifo.sv
// Purpose: Small FIFO with registered read data
// Assumes: Single clock, first word falls through one cycle after write
// Notes:   Read data and valid come from flops
`timescale 1ns/10ps
`default_nettype none

module idc_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic              mclk,
	input  wire logic              rst_n,
	// Fill side
	input  wire logic              in_valid,
	output logic                   in_ready,
	input  wire logic [WIDTH-1:0]  in_data,
	// Drain side
	output logic                   out_valid,
	input  wire logic              out_ready,
	output logic [WIDTH-1:0]       out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0]  mem [DEPTH];
	logic [AW-1:0]     wr_ptr;
	logic [AW-1:0]     rd_ptr;
	logic [AW:0]       count;
	logic              push;
	logic              pop;
	logic [AW-1:0]     next_rd_ptr;
	logic [AW:0]       next_count;

	assign in_ready    = (count != (AW+1)'(DEPTH));
	assign push        = in_valid && in_ready;
	assign pop         = out_valid && out_ready;
	assign next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
	assign next_count  = (AW+1)'(count + push - pop);

	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr    <= '0;
			rd_ptr    <= '0;
			count     <= '0;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr <= AW'(wr_ptr + 1'b1);
			end
			rd_ptr    <= next_rd_ptr;
			count     <= next_count;
			out_valid <= (next_count != '0);
		end
	end

	// Head word, bypassing a write into the head slot
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			out_data <= '0;
		end else if (push && (wr_ptr == next_rd_ptr)) begin
			out_data <= in_data;
		end else begin
			out_data <= mem[next_rd_ptr];
		end
	end

endmodule

`default_nettype wire

// >>> core/idc_front_control.sv
// Purpose: Digital control of an isolated two-channel sigma-delta front end
// Assumes: Modulator bits, sync, fault and SPI pins arrive asynchronously
// Notes:   Samples leave through an eight-word FIFO
`timescale 1ns/10ps
`default_nettype none

module idc_front_control
	import idc_pkg::*;
(
	// Clock and reset
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	// Configuration
	input  wire idc_ch_cfg_s [NCH-1:0]     channel_config,
	input  wire logic [1:0]                divider_ratio,
	input  wire logic [2:0]                osr_select,
	input  wire logic                      turbo_mode,
	// Pins
	input  wire logic [NCH-1:0]            mod_bit_pin,
	input  wire logic                      sync_reset_n_pin,
	input  wire logic                      converter_fail_pin,
	input  wire logic                      spi_cs_n_pin,
	input  wire logic                      spi_sclk_pin,
	// Status access from the SPI frame logic
	input  wire logic                      status_read,
	output logic [STS_W-1:0]               status_word,
	output logic                           converter_fault_latch,
	// Analog front-end controls
	output logic [NCH-1:0][3:0]            source_enable,
	output logic [NCH-1:0][2:0]            input_amplifier_gain,
	output logic [NCH-1:0]                 precharge_enable,
	output logic [NCH-1:0]                 carrier_burst_keying,
	output logic                           modulator_clock,
	output logic                           resonator_clock,
	// Sample stream
	output logic                           sample_valid,
	input  wire logic                      sample_ready,
	output idc_sample_s                    sample_word
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic [ASYNC_W-1:0]  async_meta;
	logic [ASYNC_W-1:0]  async_sync;
	logic [ASYNC_W-1:0]  async_prev;
	logic [NCH-1:0]      mod_bit;
	logic                sync_n;
	logic                cs_n;
	logic                sclk;
	logic                fault_level;
	logic                sync_pulse;
	logic                cs_edge;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			async_meta <= ASYNC_RST;
			async_sync <= ASYNC_RST;
			async_prev <= ASYNC_RST;
		end else begin
			async_meta <= {spi_sclk_pin, spi_cs_n_pin, sync_reset_n_pin,
				converter_fail_pin, mod_bit_pin};
			async_sync <= async_meta;
			async_prev <= async_sync;
		end
	end

	assign mod_bit     = async_sync[NCH-1:0];
	assign fault_level = async_sync[2];
	assign sync_n      = async_sync[3];
	assign cs_n        = async_sync[4];
	assign sclk        = async_sync[5];
	assign sync_pulse  = async_prev[3] && !sync_n;
	assign cs_edge     = async_prev[4] != cs_n;

	// ------------------------------------------------------------
	// Modulator clock divider
	// ------------------------------------------------------------
	logic [3:0]  div_cnt;
	logic [3:0]  active_half;
	logic [3:0]  next_half;
	logic        mod_tick;
	logic        div_toggle;

	always_comb begin
		case (divider_ratio)
			2'h0:    next_half = HALF_2;
			2'h1:    next_half = HALF_4;
			2'h2:    next_half = HALF_8;
			2'h3:    next_half = HALF_12;
			default: next_half = HALF_2;
		endcase
	end

	assign div_toggle = (div_cnt == 4'(active_half - 1'b1));

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt         <= '0;
			active_half     <= HALF_2;
			modulator_clock <= 1'b0;
			mod_tick        <= 1'b0;
		end else if (sync_pulse) begin
			div_cnt         <= '0;
			active_half     <= next_half;
			modulator_clock <= 1'b0;
			mod_tick        <= 1'b0;
		end else if (div_toggle) begin
			div_cnt         <= '0;
			active_half     <= next_half;
			modulator_clock <= !modulator_clock;
			mod_tick        <= !modulator_clock;
		end else begin
			div_cnt  <= 4'(div_cnt + 1'b1);
			mod_tick <= 1'b0;
		end
	end

	// Resonator kept in step with the modulator clock
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			resonator_clock <= 1'b0;
		end else begin
			resonator_clock <= sync_pulse ? 1'b0 :
				(div_toggle ? !modulator_clock : modulator_clock);
		end
	end

	// ------------------------------------------------------------
	// Oversampling ratio
	// ------------------------------------------------------------
	logic [3:0]          osr_log;
	logic [ACC_W-1:0]    osr_full;
	logic [PHASE_W-1:0]  osr_last;
	logic [3:0]          osr_shift;

	assign osr_log   = turbo_mode ? OSR_LOG_TURBO : 4'(OSR_LOG_BASE + osr_select);
	assign osr_full  = ACC_W'(1) << osr_log;
	assign osr_last  = PHASE_W'(osr_full - 1'b1);
	assign osr_shift = 4'(FULL_LOG - osr_log);

	// ------------------------------------------------------------
	// Per-channel front end, decimation and calibration
	// ------------------------------------------------------------
	logic [NCH-1:0]                 pend;
	logic [NCH-1:0]                 grant;
	logic [NCH-1:0]                 drop;
	logic [NCH-1:0][SAMPLE_W-1:0]   pend_data;
	logic                           fifo_in_ready;
	logic                           fifo_in_valid;
	idc_sample_s                    fifo_in;

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++) begin : g_ch
			logic [PHASE_W-1:0]         win;
			logic [ACC_W-1:0]           acc;
			logic [ACC_W-1:0]           ones;
			logic signed [16:0]         diff;
			logic signed [16:0]         scaled;
			logic signed [SAMPLE_W-1:0] raw;
			logic                       raw_valid;
			logic signed [16:0]         centred;
			logic signed [33:0]         prod;
			logic signed [33:0]         prod_sh;
			logic [SAMPLE_W-1:0]        cal;
			logic                       cal_valid;
			logic [SAMPLE_W-1:0]        cal_data;

			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					source_enable[ch]        <= 4'h1;
					input_amplifier_gain[ch] <= '0;
					precharge_enable[ch]     <= 1'b0;
				end else begin
					source_enable[ch] <= 4'h1 << channel_config[ch].input_source_select;
					input_amplifier_gain[ch] <= channel_config[ch].channel_gain_select;
					precharge_enable[ch] <=
						channel_config[ch].channel_gain_select >= PRECHARGE_MIN_GAIN;
				end
			end

			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					carrier_burst_keying[ch] <= 1'b0;
				end else if (mod_tick) begin
					carrier_burst_keying[ch] <= mod_bit[ch];
				end
			end

			// Sinc window: count ones over the ratio
			assign ones   = ACC_W'(acc + mod_bit[ch]);
			assign diff   = $signed({1'b0, ones, 1'b0}) - $signed({2'b0, osr_full});
			assign scaled = diff <<< osr_shift;

			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					win       <= '0;
					acc       <= '0;
					raw       <= '0;
					raw_valid <= 1'b0;
				end else if (sync_pulse) begin
					win       <= channel_config[ch].phase;
					acc       <= '0;
					raw_valid <= 1'b0;
				end else if (mod_tick && (win >= osr_last)) begin
					win       <= '0;
					acc       <= '0;
					raw       <= (scaled > $signed({1'b0, SAMPLE_MAX})) ?
						$signed(SAMPLE_MAX) : scaled[SAMPLE_W-1:0];
					raw_valid <= 1'b1;
				end else begin
					if (mod_tick) begin
						win <= PHASE_W'(win + 1'b1);
						acc <= ones;
					end
					raw_valid <= 1'b0;
				end
			end

			assign centred = {raw[SAMPLE_W-1], raw} - {channel_config[ch].cal_offset[CAL_W-1],
				channel_config[ch].cal_offset};
			assign prod    = centred * $signed({1'b0, channel_config[ch].cal_gain});
			assign prod_sh = prod >>> CAL_FRAC;

			always_comb begin
				if (prod_sh > $signed({18'h0, SAMPLE_MAX})) begin
					cal = SAMPLE_MAX;
				end else if (prod_sh < $signed({18'h3ffff, SAMPLE_MIN})) begin
					cal = SAMPLE_MIN;
				end else begin
					cal = prod_sh[SAMPLE_W-1:0];
				end
			end

			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					cal_valid <= 1'b0;
					cal_data  <= '0;
				end else begin
					cal_valid <= raw_valid;
					cal_data  <= cal;
				end
			end

			// Holding slot; a full slot that is not granted keeps its word and drops the newcomer
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					pend[ch]      <= 1'b0;
					pend_data[ch] <= '0;
				end else if (cal_valid && (!pend[ch] || grant[ch])) begin
					pend[ch]      <= 1'b1;
					pend_data[ch] <= cal_data;
				end else if (grant[ch]) begin
					pend[ch] <= 1'b0;
				end
			end

			assign drop[ch] = cal_valid && pend[ch] && !grant[ch];

			sync_phase_a: assert property (@(posedge mclk) disable iff (!rst_n)
				sync_pulse |=> win == $past(channel_config[ch].phase))
				else $error("window not realigned by sync");
			carrier_key_a: assert property (@(posedge mclk) disable iff (!rst_n)
				mod_tick |=> carrier_burst_keying[ch] == $past(mod_bit[ch]))
				else $error("carrier keying does not follow bit");
			precharge_gain_a: assert property (@(posedge mclk) disable iff (!rst_n)
				precharge_enable[ch] == (input_amplifier_gain[ch] >= PRECHARGE_MIN_GAIN))
				else $error("precharge buffer mismatches gain");
			mux_onehot_a: assert property (@(posedge mclk) disable iff (!rst_n)
				$onehot(source_enable[ch]))
				else $error("source select not one-hot");
		end
	endgenerate

	// ------------------------------------------------------------
	// Arbiter into the FIFO, channel 0 first
	// ------------------------------------------------------------
	assign grant[0]      = pend[0] && fifo_in_ready;
	assign grant[1]      = pend[1] && !pend[0] && fifo_in_ready;
	assign fifo_in_valid = |grant;
	assign fifo_in.chan  = !grant[0];
	assign fifo_in.data  = grant[0] ? pend_data[0] : pend_data[1];

	idc_fifo #(
		.WIDTH ($bits(idc_sample_s)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in),
		.out_valid (sample_valid),
		.out_ready (sample_ready),
		.out_data  (sample_word)
	);

	// ------------------------------------------------------------
	// Status flags: set wins over read clear
	// ------------------------------------------------------------
	logic  spi_err;
	logic  overrun;
	logic  spi_err_set;

	assign spi_err_set = cs_edge && (sclk != SPI_CPOL);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			converter_fault_latch <= 1'b0;
		end else if (fault_level) begin
			converter_fault_latch <= 1'b1;
		end else if (status_read) begin
			converter_fault_latch <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			spi_err <= 1'b0;
			overrun <= 1'b0;
		end else begin
			spi_err <= spi_err_set || (spi_err && !status_read);
			overrun <= (|drop) || (overrun && !status_read);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			status_word <= '0;
		end else if (status_read) begin
			status_word[STS_FAULT]   <= converter_fault_latch || fault_level;
			status_word[STS_SPI_ERR] <= spi_err || spi_err_set;
			status_word[STS_OVERRUN] <= overrun || (|drop);
		end
	end

	fault_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
		fault_level |=> converter_fault_latch)
		else $error("fault not latched");
	fault_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
		converter_fault_latch && !status_read |=> converter_fault_latch)
		else $error("fault latch dropped without read");
	fault_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		status_read && !fault_level |=> !converter_fault_latch ##0 status_word[STS_FAULT]
		== $past(converter_fault_latch))
		else $error("status read did not clear fault");
	div_two_a: assert property (@(posedge mclk) disable iff (!rst_n)
		($rose(modulator_clock) && active_half == HALF_2 && divider_ratio == DIV_CODE_RESET)
		##1 (divider_ratio == DIV_CODE_RESET && !sync_pulse) |=> $rose(modulator_clock))
		else $error("modulator clock not mclk over two");
	div_twelve_a: assert property (@(posedge mclk) disable iff (!rst_n)
		($rose(modulator_clock) && active_half == HALF_12 && !sync_pulse) ##1 (!sync_pulse) [*4]
		|=> !$fell(modulator_clock) ##1 $fell(modulator_clock))
		else $error("ratio twelve half period wrong");
	resonator_a: assert property (@(posedge mclk) disable iff (!rst_n)
		resonator_clock == modulator_clock)
		else $error("resonator out of step");
	fifo_push_a: assert property (@(posedge mclk) disable iff (!rst_n)
		fifo_in_valid |-> fifo_in_ready ##0 $onehot(grant))
		else $error("push into full fifo");
	spi_mode_a: assert property (@(posedge mclk) disable iff (!rst_n)
		spi_err_set |=> spi_err)
		else $error("select edge with clock high not flagged");

endmodule

`default_nettype wire

// >>> verif/idc_host_model.sv
// Purpose: Host-side reader of the sample stream, with seeded stalls
// Assumes: A word is taken on each edge where valid and ready are both high
// Notes:   Taken words wait in one queue per channel for the bench
`timescale 1ns/10ps
`default_nettype none

module idc_host_model
	import idc_pkg::*;
(
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_n,
	// Bench control
	input  wire logic         stall,
	// Sample stream
	input  wire logic         sample_valid,
	output logic              sample_ready,
	input  wire idc_sample_s  sample_word
);
	int           seed = 46905;
	logic [15:0]  got0[$];
	logic [15:0]  got1[$];

	// ------------------------------------------------------------
	// Ready, random and held low while stalled
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			sample_ready <= 1'b0;
		else
			sample_ready <= !stall && (($random(seed) & 3) != 0);
	end

	// ------------------------------------------------------------
	// Collect taken words
	// ------------------------------------------------------------
	always @(posedge mclk) begin
		if (rst_n && sample_valid && sample_ready) begin
			if (sample_word.chan)
				got1.push_back(sample_word.data);
			else
				got0.push_back(sample_word.data);
		end
	end
endmodule
`default_nettype wire

// >>> verif/isolated_dual_adc_front_control_test.sv
// Purpose: Self-checking bench for the dual converter control
// Assumes: Pins change on the rising edge by non-blocking assignment
// Notes:   Expected samples come from ones count and calibration
`timescale 1ns/10ps
`default_nettype none

module isolated_dual_adc_front_control_test
	import idc_pkg::*;
;
	logic                   mclk = 1'b0;
	logic                   rst_n = 1'b0;
	idc_ch_cfg_s [NCH-1:0]  channel_config = '0;
	idc_ch_cfg_s [NCH-1:0]  cfg;
	logic [1:0]             divider_ratio = 2'h0;
	logic [NCH-1:0]         mod_bit_pin = '0;
	logic                   converter_fail_pin = 1'b0;
	logic                   status_read = 1'b0;
	logic                   stall = 1'b1;
	logic                   turbo_mode = 1'b1;
	logic                   sync_n = 1'b1;
	logic                   spi_cs_n = 1'b1;
	logic                   spi_sclk = 1'b0;
	logic [STS_W-1:0]       status_word;
	logic [STS_W-1:0]       sts;
	logic                   converter_fault_latch;
	logic [NCH-1:0][3:0]    source_enable;
	logic [NCH-1:0][2:0]    input_amplifier_gain;
	logic [NCH-1:0]         precharge_enable;
	logic [NCH-1:0]         carrier_burst_keying;
	logic                   modulator_clock;
	logic                   resonator_clock;
	logic                   sample_valid;
	logic                   sample_ready;
	idc_sample_s            sample_word;
	int                     seed = 46905;
	int                     fail_count = 0;
	int                     checks_done = 0;
	int                     sel[NCH];
	int                     gn[NCH];
	int                     half;
	int                     n;

	idc_front_control dut (
		.mclk(mclk), .rst_n(rst_n), .channel_config(channel_config),
		.divider_ratio(divider_ratio), .osr_select(3'h0), .turbo_mode(turbo_mode),
		.mod_bit_pin(mod_bit_pin), .sync_reset_n_pin(sync_n),
		.converter_fail_pin(converter_fail_pin), .spi_cs_n_pin(spi_cs_n),
		.spi_sclk_pin(spi_sclk), .status_read(status_read), .status_word(status_word),
		.converter_fault_latch(converter_fault_latch), .source_enable(source_enable),
		.input_amplifier_gain(input_amplifier_gain), .precharge_enable(precharge_enable),
		.carrier_burst_keying(carrier_burst_keying), .modulator_clock(modulator_clock),
		.resonator_clock(resonator_clock), .sample_valid(sample_valid),
		.sample_ready(sample_ready), .sample_word(sample_word)
	);

	idc_host_model host (
		.mclk(mclk), .rst_n(rst_n), .stall(stall), .sample_valid(sample_valid),
		.sample_ready(sample_ready), .sample_word(sample_word)
	);

	initial begin
		forever #2.5 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// Compare, expectation and bus tasks
	// ------------------------------------------------------------
	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_flag(input string name, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask

	function automatic longint sat16(input longint v);
		return (v > 32767) ? 32767 : ((v < -32768) ? -32768 : v);
	endfunction

	// One window of OSR 2**lg, then offset and gain correction
	function automatic logic [15:0] exp_sample(input int ones, input int lg, input int off,
		input int g);
		longint raw;
		longint v;
		raw = sat16(longint'(2 * ones - (1 << lg)) <<< (15 - lg));
		v = sat16(((raw - off) * g) >>> 15);
		return v[15:0];
	endfunction

	task automatic read_status();
		@(posedge mclk) status_read <= 1'b1;
		@(posedge mclk) status_read <= 1'b0;
		@(posedge mclk);
		@(negedge mclk) sts = status_word;
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge mclk);
		fail_count++;
		summarize();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(negedge mclk);
		chk_word("src reset", 32'h1, source_enable[0]);
		chk_flag("fault reset", 1'b0, converter_fault_latch);
		@(posedge mclk) rst_n <= 1'b1;
		repeat (4) @(negedge mclk);
		chk_flag("fault after reset", 1'b0, converter_fault_latch);
		read_status();
		read_status();
		chk_flag("fault idle", 1'b0, sts[STS_FAULT]);
		// Sources and gains: every code first, then random
		for (int i = 0; i < 16; i++) begin
			cfg = channel_config;
			for (int c = 0; c < NCH; c++) begin
				sel[c] = (i < 4) ? i : ($random(seed) & 3);
				gn[c] = (i < 8) ? i : ($random(seed) & 7);
				cfg[c].input_source_select = idc_src_e'(sel[c]);
				cfg[c].channel_gain_select = gn[c][2:0];
			end
			@(posedge mclk) channel_config <= cfg;
			repeat (2) @(posedge mclk);
			@(negedge mclk);
			for (int c = 0; c < NCH; c++) begin
				chk_word("source", 32'h1 << sel[c], source_enable[c]);
				chk_word("gain", gn[c], input_amplifier_gain[c]);
				chk_flag("precharge", gn[c] >= 3, precharge_enable[c]);
			end
		end
		// Fault that recovers, then one that persists
		@(posedge mclk) converter_fail_pin <= 1'b1;
		repeat (6) @(posedge mclk);
		converter_fail_pin <= 1'b0;
		repeat (6) @(negedge mclk);
		chk_flag("fault held", 1'b1, converter_fault_latch);
		read_status();
		chk_flag("fault read", 1'b1, sts[STS_FAULT]);
		chk_flag("fault cleared", 1'b0, converter_fault_latch);
		read_status();
		chk_flag("fault second", 1'b0, sts[STS_FAULT]);
		@(posedge mclk) converter_fail_pin <= 1'b1;
		repeat (6) @(posedge mclk);
		read_status();
		read_status();
		chk_flag("fault present", 1'b1, sts[STS_FAULT]);
		@(posedge mclk) converter_fail_pin <= 1'b0;
		read_status();
		// Select moved with the serial clock high, then legally
		@(posedge mclk) spi_sclk <= 1'b1;
		repeat (4) @(posedge mclk);
		spi_cs_n <= 1'b0;
		repeat (4) @(posedge mclk);
		spi_sclk <= 1'b0;
		repeat (4) @(posedge mclk);
		spi_cs_n <= 1'b1;
		read_status();
		chk_flag("select error", 1'b1, sts[STS_SPI_ERR]);
		read_status();
		chk_flag("select legal", 1'b0, sts[STS_SPI_ERR]);
		// Streams of all ones and all zeros, fixed then random calibration
		for (int p = 0; p < 2; p++) begin
			cfg = channel_config;
			for (int c = 0; c < NCH; c++) begin
				cfg[c].phase = '0;
				cfg[c].cal_offset = (p == 0) ? 16'h0100 * (1 - c) : ($random(seed) & 16'h1fff) - 16'h0fff;
				cfg[c].cal_gain = (p == 0) ? 16'h8000 >> c : 16'h4000 + ($random(seed) & 16'h7fff);
			end
			@(posedge mclk) begin
				channel_config <= cfg;
				mod_bit_pin <= (p == 0) ? 2'b01 : 2'b10;
				turbo_mode <= (p == 0);
				stall <= 1'b0;
			end
			repeat (400) @(posedge mclk);
			@(negedge mclk);
			chk_word("keying", (p == 0) ? 32'h1 : 32'h2, carrier_burst_keying);
			host.got0.delete();
			host.got1.delete();
			n = 0;
			while ((host.got0.size() < 4 || host.got1.size() < 4) && n < 3000) begin
				@(posedge mclk);
				n++;
			end
			chk_flag("stream alive", 1'b1, n < 3000);
			foreach (host.got0[k]) begin
				chk_word("chan0", exp_sample((64 << p) * (1 - p), 6 + p, cfg[0].cal_offset,
					cfg[0].cal_gain), host.got0[k]);
			end
			foreach (host.got1[k]) begin
				chk_word("chan1", exp_sample((64 << p) * p, 6 + p, cfg[1].cal_offset,
					cfg[1].cal_gain), host.got1[k]);
			end
			chk_flag("paired", 1'b1, host.got0.size() - host.got1.size() <= 1);
		end
		// Sync realigns windows, channel 1 preset half way
		cfg[1].phase = 14'h20;
		@(posedge mclk) begin
			channel_config <= cfg;
			turbo_mode <= 1'b1;
			sync_n <= 1'b0;
		end
		repeat (20) @(posedge mclk);
		sync_n <= 1'b1;
		host.got0.delete();
		host.got1.delete();
		repeat (400) @(posedge mclk);
		chk_word("sync chan0", exp_sample(0, 6, cfg[0].cal_offset, cfg[0].cal_gain),
			host.got0[0]);
		chk_word("sync chan1", exp_sample(32, 6, cfg[1].cal_offset, cfg[1].cal_gain),
			host.got1[0]);
		// Host stalls until the buffer overflows, then drains
		@(posedge mclk) stall <= 1'b1;
		repeat (1600) @(posedge mclk);
		read_status();
		chk_flag("overrun", 1'b1, sts[STS_OVERRUN]);
		@(posedge mclk) stall <= 1'b0;
		repeat (100) @(posedge mclk);
		read_status();
		read_status();
		chk_flag("overrun cleared", 1'b0, sts[STS_OVERRUN]);
		// Divider codes and their half periods
		for (int d = 0; d < 4; d++) begin
			@(posedge mclk) divider_ratio <= d[1:0];
			repeat (40) @(posedge mclk);
			@(negedge mclk);
			while (modulator_clock !== 1'b0) @(negedge mclk);
			while (modulator_clock !== 1'b1) @(negedge mclk);
			half = 0;
			while (modulator_clock === 1'b1 && half < 20) begin
				chk_flag("resonator", modulator_clock, resonator_clock);
				half++;
				@(negedge mclk);
			end
			chk_word("half period", (d == 3) ? 6 : (1 << d), half);
		end
		summarize();
	end
endmodule
`default_nettype wire
